// >>> rtl/wdm_pkg.sv
// package for the watchdog service and monitor register bank
// assumes an 8-bit register port, byte addressed, one bus clock
package wdm_pkg;
   // -------------------------------------------------------------
   // register map
   // -------------------------------------------------------------
   localparam logic [9:0] ADDR_WATCHDOG_SERVICE   = 10'h03f;
   localparam logic [9:0] ADDR_TEMP_MONITOR_CTL   = 10'h2f0;
   localparam logic [9:0] ADDR_LOW_VOLT_MONITOR_CTL = 10'h2f1;
   // -------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------
   localparam int BIT_VOLT_ROUTE  = 5;
   localparam int BIT_SENSOR_EN   = 3;
   localparam int BIT_STATUS      = 2;
   localparam int BIT_IRQ_EN      = 1;
   localparam int BIT_CHANGE_FLAG = 0;
   // -------------------------------------------------------------
   // service codes and values
   // -------------------------------------------------------------
   localparam logic [7:0] SERVICE_ARM     = 8'h55;
   localparam logic [7:0] SERVICE_RESTART = 8'haa;
   localparam logic [7:0] READ_ZERO       = 8'h00;
   localparam logic [2:0] RATE_DISABLED   = 3'h0;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [9:0] addr;
      logic [7:0] wdata;
   } wdm_bus_s;

   typedef enum logic [0:0] {
      WDM_IDLE  = 1'b0,
      WDM_ARMED = 1'b1
   } wdm_arm_e;
endpackage : wdm_pkg

// >>> rtl/wdm_bank.sv
// watchdog service register plus temperature and low-voltage monitor
// registers; assumes an external watchdog counter supplies rate,
// window mode, window phase and expiry, and analog comparators
// drive asynchronous level inputs.
// also assumes the bus never strobes read and write in one cycle
// and that period_expired is a single-cycle pulse.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
module wdm_bank
   import wdm_pkg::*;
(
   input  wire logic       clk,              // bus clock, 200 mhz
   input  wire logic       rstn,             // async reset, active low
   input  wire logic [9:0] addr,             // register byte address
   input  wire logic [7:0] wdata,            // write data
   input  wire logic       wr,               // write strobe
   input  wire logic       rd,               // read strobe
   output logic      [7:0] rdata,            // read data, cycle after rd
   input  wire logic [2:0] watchdog_rate_select, // from counter config
   input  wire logic       window_watchdog_mode, // from counter config
   input  wire logic       window_open,      // counter in last quarter
   input  wire logic       period_expired,   // counter end-of-period
   output logic            watchdog_restart, // pulse, restart counter
   output logic            watchdog_enable,  // counter enabled
   output logic            watchdog_reset_req, // pulse, system reset
   input  wire logic       temp_comp_async,  // over-temperature comp
   input  wire logic       low_volt_comp_async, // analog_supply low
   output logic            temp_sensor_enable, // sensor power
   output logic            voltage_route_select, // 1 bandgap, 0 temp
   output logic            temp_irq,         // temperature irq
   output logic            low_volt_irq      // low-voltage irq
);

   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   // one struct carries the strobes so every decoder sees one bundle
   wdm_bus_s bus;
   assign bus = '{wr: wr, rd: rd, addr: addr, wdata: wdata};

   logic wr_service;
   logic wr_temp;
   logic wr_lv;
   assign wr_service = bus.wr && (bus.addr == ADDR_WATCHDOG_SERVICE);
   assign wr_temp    = bus.wr && (bus.addr == ADDR_TEMP_MONITOR_CTL);
   assign wr_lv      = bus.wr && (bus.addr == ADDR_LOW_VOLT_MONITOR_CTL);

   // ------------------------------------------------------------
   // watchdog arming sequence
   // ------------------------------------------------------------
   wdm_arm_e arm_state;
   wdm_arm_e next_arm_state;
   logic     enabled;
   logic     bad_write;
   logic     good_pair;

   assign enabled = (watchdog_rate_select != RATE_DISABLED);

   always_comb begin
      next_arm_state = arm_state;
      bad_write      = 1'b0;
      good_pair      = 1'b0;
      if (!enabled) begin
         next_arm_state = WDM_IDLE;
      end else if (wr_service) begin
         if (window_watchdog_mode && !window_open) begin
            bad_write      = 1'b1;
            next_arm_state = WDM_IDLE;
         end else if (bus.wdata == SERVICE_ARM) begin
            next_arm_state = WDM_ARMED;
         end else if (bus.wdata == SERVICE_RESTART) begin
            // pair completes restart
            // a lone 0xaa neither restarts nor resets; only the pair
            // counts, so a stray restart byte is simply dropped
            good_pair      = (arm_state == WDM_ARMED);
            next_arm_state = WDM_IDLE;
         end else begin
            bad_write      = 1'b1;
            next_arm_state = WDM_IDLE;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         arm_state <= WDM_IDLE;
      end else if (good_pair || period_expired) begin
         // a restart or expiry closes any half-done pair
         arm_state <= WDM_IDLE;
      end else begin
         arm_state <= next_arm_state;
      end
   end

   // ------------------------------------------------------------
   // watchdog outputs to the counter and the system reset logic
   // ------------------------------------------------------------
   // the counter sees the enable one cycle late; a rate change to disabled
   // in mid-pair is already handled above by dropping the pair
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         watchdog_enable <= 1'b0;
      end else begin
         watchdog_enable <= enabled;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         watchdog_restart <= 1'b0;
      end else begin
         watchdog_restart <= good_pair;
      end
   end

   // one pulse per event; the system reset logic stretches it
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         watchdog_reset_req <= 1'b0;
      end else begin
         watchdog_reset_req <= bad_write || (enabled && period_expired);
      end
   end

   // ------------------------------------------------------------
   // comparator synchronisers
   // ------------------------------------------------------------
   logic [1:0] comp_meta;
   logic [1:0] comp_sync;
   // the comparators are slow analog levels, so two flops suffice;
   // the status registers below double as the edge history
   // two-flop sync
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         comp_meta <= 2'h0;
         comp_sync <= 2'h0;
      end else begin
         comp_meta <= {low_volt_comp_async, temp_comp_async};
         comp_sync <= comp_meta;
      end
   end

   // ------------------------------------------------------------
   // start-up sequencing
   // ------------------------------------------------------------
   // the synchroniser shows its reset value for two edges after
   // release, so comparator levels are trusted from the third edge
   // on; reads in the first cycles after reset show reset values
   logic lv_primed;
   logic prime_done;
   logic sync_valid;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lv_primed  <= 1'b0;
         prime_done <= 1'b0;
         sync_valid <= 1'b0;
      end else begin
         lv_primed  <= 1'b1;
         prime_done <= lv_primed;
         sync_valid <= prime_done;
      end
   end

   // ------------------------------------------------------------
   // temperature monitor register
   // ------------------------------------------------------------
   logic temp_status;
   logic temp_change_flag;
   logic temp_irq_enable;
   logic temp_changed;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         temp_status <= 1'b0;
      end else begin
         temp_status <= comp_sync[0];
      end
   end
   assign temp_changed = sync_valid && (comp_sync[0] != temp_status);

   // ------------------------------------------------------------
   // temperature control bits
   // ------------------------------------------------------------
   // route select
   // a plain mux select; with the sensor off neither route carries
   // a valid voltage, which software has to respect
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         voltage_route_select <= 1'b0;
      end else if (wr_temp) begin
         voltage_route_select <= bus.wdata[BIT_VOLT_ROUTE];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         temp_sensor_enable <= 1'b0;
      end else if (wr_temp) begin
         temp_sensor_enable <= bus.wdata[BIT_SENSOR_EN];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         temp_irq_enable <= 1'b0;
      end else if (wr_temp) begin
         temp_irq_enable <= bus.wdata[BIT_IRQ_EN];
      end
   end

   // ------------------------------------------------------------
   // temperature change flag
   // ------------------------------------------------------------
   // set beats a same-cycle clear so no change is lost
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         temp_change_flag <= 1'b0;
      end else if (temp_changed) begin
         temp_change_flag <= 1'b1;
      end else if (wr_temp && bus.wdata[BIT_CHANGE_FLAG]) begin
         temp_change_flag <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // low-voltage monitor register
   // ------------------------------------------------------------
   logic lv_status;
   logic low_volt_change_flag;
   logic low_volt_irq_enable;
   logic lv_changed;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         lv_status <= 1'b0;
      end else begin
         lv_status <= comp_sync[1];
      end
   end
   assign lv_changed = sync_valid && (comp_sync[1] != lv_status);

   // ------------------------------------------------------------
   // low-voltage control bits
   // ------------------------------------------------------------
   // enable writable anytime
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         low_volt_irq_enable <= 1'b0;
      end else if (wr_lv) begin
         low_volt_irq_enable <= bus.wdata[BIT_IRQ_EN];
      end
   end

   // ------------------------------------------------------------
   // low-voltage change flag
   // ------------------------------------------------------------
   // loaded once from the settled supply state, then edge driven
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         low_volt_change_flag <= 1'b0;
      end else if (prime_done && !sync_valid) begin
         // flag follows supply state at reset
         low_volt_change_flag <= comp_sync[1];
      end else if (lv_changed) begin
         low_volt_change_flag <= 1'b1;
      end else if (wr_lv && bus.wdata[BIT_CHANGE_FLAG]) begin
         low_volt_change_flag <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // interrupt requests
   // ------------------------------------------------------------
   // registered so the outputs come from flops; the request lags
   // the flag by one cycle, which a level interrupt tolerates
   // flag and enable
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         temp_irq <= 1'b0;
      end else begin
         temp_irq <= temp_change_flag && temp_irq_enable;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         low_volt_irq <= 1'b0;
      end else begin
         low_volt_irq <= low_volt_change_flag && low_volt_irq_enable;
      end
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   logic [7:0] next_rdata;
   always_comb begin
      next_rdata = READ_ZERO;
      if (bus.rd) begin
         unique case (bus.addr)
            ADDR_TEMP_MONITOR_CTL: begin
               next_rdata[BIT_VOLT_ROUTE]  = voltage_route_select;
               next_rdata[BIT_SENSOR_EN]   = temp_sensor_enable;
               next_rdata[BIT_STATUS]      = temp_status;
               next_rdata[BIT_IRQ_EN]      = temp_irq_enable;
               next_rdata[BIT_CHANGE_FLAG] = temp_change_flag;
            end
            ADDR_LOW_VOLT_MONITOR_CTL: begin
               next_rdata[BIT_STATUS]      = lv_status;
               next_rdata[BIT_IRQ_EN]      = low_volt_irq_enable;
               next_rdata[BIT_CHANGE_FLAG] = low_volt_change_flag;
            end
            // unmapped reads give zero so probing software sees no noise
            // service reads zero; unmapped also zero
            default: next_rdata = READ_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= READ_ZERO;
      end else begin
         rdata <= next_rdata;
      end
   end

endmodule : wdm_bank

// >>> verif/wdm_chk.sv
// checker for the watchdog service and monitor register bank
// assumes a bind into wdm_bank, one clock, async active-low reset
`timescale 1ns/100ps
module wdm_chk
   import wdm_pkg::*;
(
   input wire logic       clk,                  // clock
   input wire logic       rstn,                 // reset
   input wire logic [9:0] addr,                 // address
   input wire logic [7:0] wdata,                // write data
   input wire logic       wr,                   // write
   input wire logic       rd,                   // read
   input wire logic [7:0] rdata,                // read data
   input wire logic [2:0] watchdog_rate_select, // rate
   input wire logic       window_watchdog_mode, // window mode
   input wire logic       window_open,          // last quarter
   input wire logic       period_expired,       // expiry
   input wire logic       watchdog_restart,     // restart
   input wire logic       watchdog_enable,      // enable
   input wire logic       watchdog_reset_req,   // reset request
   input wire logic       temp_comp_async,      // temp comparator
   input wire logic       low_volt_comp_async   // supply comparator
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // ----
   // helpers
   // ----
   logic svc_w;
   logic wd_on;
   logic aa_q;
   assign svc_w = wr && addr == ADDR_WATCHDOG_SERVICE;
   // both the input and its registered copy, so a rate change is settled
   assign wd_on = watchdog_enable && watchdog_rate_select != RATE_DISABLED;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) aa_q <= 1'b0;
      else aa_q <= svc_w && wdata == SERVICE_RESTART;
   end
   // ----
   // properties
   // ----
   AST_RD_ZERO:
      assert property (rd && addr == ADDR_WATCHDOG_SERVICE |=> !rdata)
         else $error("service read not zero");
   AST_OFF_IGNORE:
      assert property (svc_w && !watchdog_rate_select && !watchdog_enable
         |=> !watchdog_reset_req && !watchdog_restart)
         else $error("disabled service write had effect");
   AST_BAD_BYTE:
      assert property (svc_w && wd_on && wdata != SERVICE_ARM
         && wdata != SERVICE_RESTART |=> watchdog_reset_req)
         else $error("bad byte without reset");
   AST_RESTART_SRC:
      assert property (watchdog_restart |-> aa_q)
         else $error("restart without restart byte");
   AST_EXPIRY:
      assert property (period_expired && wd_on |=> watchdog_reset_req)
         else $error("expiry without reset");
   AST_EARLY:
      assert property (svc_w && wd_on && window_watchdog_mode
         && !window_open |=> watchdog_reset_req)
         else $error("early window write without reset");
   AST_TSTAT:
      assert property ($stable(temp_comp_async) [*6] ##1
         (rd && addr == ADDR_TEMP_MONITOR_CTL)
         |=> rdata[BIT_STATUS] == $past(temp_comp_async, 2))
         else $error("temperature status wrong");
   AST_LSTAT:
      assert property ($stable(low_volt_comp_async) [*6] ##1
         (rd && addr == ADDR_LOW_VOLT_MONITOR_CTL)
         |=> rdata[BIT_STATUS] == $past(low_volt_comp_async, 2))
         else $error("low-voltage status wrong");
   COV_RESTART: cover property (watchdog_restart);
   COV_RESET: cover property (watchdog_reset_req);
   COV_WINDOW: cover property (svc_w && window_watchdog_mode && window_open);
endmodule : wdm_chk
bind wdm_bank wdm_chk u_chk (.clk, .rstn, .addr, .wdata, .wr, .rd, .rdata,
   .watchdog_rate_select, .window_watchdog_mode, .window_open,
   .period_expired, .watchdog_restart, .watchdog_enable,
   .watchdog_reset_req, .temp_comp_async, .low_volt_comp_async);

// >>> verif/tb_top.sv
// self-checking bench for the watchdog service and monitor bank
// assumes wdm_pkg, wdm_bank and the checker are compiled first
`timescale 1ns/100ps
module tb_top;
   import wdm_pkg::*;
   localparam logic [9:0] TMP = ADDR_TEMP_MONITOR_CTL;
   localparam logic [9:0] LV  = ADDR_LOW_VOLT_MONITOR_CTL;
   logic       clk = 1'b0;
   logic       rstn = 1'b0;
   logic [9:0] addr = '0;
   logic [7:0] wdata = '0;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic [2:0] rate = '0;
   logic       wmode = 1'b0;
   logic       wopen = 1'b0;
   logic       pexp = 1'b0;
   logic       tcomp = 1'b0;
   // supply comparator high through reset sets the flag at reset
   logic       lcomp = 1'b1;
   logic [7:0] rdata;
   logic       rs, en, rst, ten, vr, tirq, lirq, g_rs, g_rst;
   int         failures = 0;
   int         total_checks = 0;
   int         cyc = 0;
   always #2.5 clk = ~clk;
   wdm_bank DUT (.clk, .rstn, .addr, .wdata, .wr, .rd, .rdata,
      .watchdog_rate_select(rate), .window_watchdog_mode(wmode),
      .window_open(wopen), .period_expired(pexp),
      .watchdog_restart(rs), .watchdog_enable(en),
      .watchdog_reset_req(rst), .temp_comp_async(tcomp),
      .low_volt_comp_async(lcomp), .temp_sensor_enable(ten),
      .voltage_route_select(vr), .temp_irq(tirq), .low_volt_irq(lirq));
   // ----
   // bus and compare tasks
   // ----
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [9:0] a,
                      input logic [7:0] d);
      @(posedge clk);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
      g_rs = rs;
      g_rst = rst;
   endtask : bus
   task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      chk(rdata, exp);
   endtask : rd_chk
   task automatic svc(input logic [7:0] d, input logic ers, erst);
      bus(1'b1, ADDR_WATCHDOG_SERVICE, d);
      chk({6'h0, g_rs, g_rst}, {6'h0, ers, erst});
   endtask : svc
   task automatic comp_wait();
      repeat (6) @(posedge clk);
   endtask : comp_wait
   // ----
   // scenarios
   // ----
   task automatic t_lv();
      rd_chk(LV, 8'h05);
      bus(1'b1, LV, 8'h07);
      rd_chk(LV, 8'h06);
      @(posedge clk) lcomp <= 1'b0;
      comp_wait();
      rd_chk(LV, 8'h03);
      chk({7'h0, lirq}, 8'h01);
      bus(1'b1, LV, 8'h02);
      rd_chk(LV, 8'h03);
      bus(1'b1, LV, 8'h01);
      rd_chk(LV, 8'h00);
      chk({7'h0, lirq}, 8'h00);
      // unmapped place: write lost, read gives zero
      bus(1'b1, 10'h2f2, 8'hff);
      rd_chk(10'h2f2, 8'h00);
   endtask : t_lv
   task automatic t_svc();
      rd_chk(ADDR_WATCHDOG_SERVICE, 8'h00);
      svc(8'h12, 1'b0, 1'b0);
      chk({7'h0, en}, 8'h00);
      @(posedge clk) rate <= 3'h3;
      svc(SERVICE_ARM, 1'b0, 1'b0);
      chk({7'h0, en}, 8'h01);
      svc(SERVICE_ARM, 1'b0, 1'b0);
      svc(SERVICE_RESTART, 1'b1, 1'b0);
      svc(SERVICE_RESTART, 1'b0, 1'b0);
      svc(8'h00, 1'b0, 1'b1);
      @(posedge clk) pexp <= 1'b1;
      @(posedge clk) pexp <= 1'b0;
      #1;
      chk({7'h0, rst}, 8'h01);
      @(posedge clk) wmode <= 1'b1;
      svc(SERVICE_ARM, 1'b0, 1'b1);
      @(posedge clk) wopen <= 1'b1;
      svc(SERVICE_ARM, 1'b0, 1'b0);
      rd_chk(ADDR_WATCHDOG_SERVICE, 8'h00);
      svc(SERVICE_RESTART, 1'b1, 1'b0);
      rd_chk(ADDR_WATCHDOG_SERVICE, 8'h00);
   endtask : t_svc
   task automatic t_temp();
      bus(1'b1, TMP, 8'hff);
      rd_chk(TMP, 8'h2a);
      chk({6'h0, vr, ten}, 8'h03);
      @(posedge clk) tcomp <= 1'b1;
      comp_wait();
      rd_chk(TMP, 8'h2f);
      chk({7'h0, tirq}, 8'h01);
      bus(1'b1, TMP, 8'h2a);
      rd_chk(TMP, 8'h2f);
      bus(1'b1, TMP, 8'h03);
      rd_chk(TMP, 8'h06);
      chk({5'h0, vr, ten, tirq}, 8'h00);
      @(posedge clk) tcomp <= 1'b0;
      comp_wait();
      rd_chk(TMP, 8'h03);
   endtask : t_temp
   task automatic final_report();
      if (failures == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : final_report
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         failures++;
         final_report();
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      // comparator states settle through the synchroniser first
      comp_wait();
      t_lv();
      t_svc();
      t_temp();
      final_report();
   end
endmodule : tb_top
